// ### dtm_timers.sv
module dtm_timers
  import dtm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_we,
  input wire logic sfr_re,
  input wire logic sfr_bit_we,
  input wire logic [7:0] sfr_bit_addr,
  input wire logic sfr_bit_val,
  output logic [7:0] sfr_rdata,
  input wire logic timer_zero_count_pin,
  input wire logic timer_one_count_pin,
  input wire logic ext_input_zero,
  input wire logic ext_input_one,
  input wire logic ext_zero_polarity,
  input wire logic ext_one_polarity,
  input wire logic ext_clk,
  input wire logic ext_zero_set,
  input wire logic ext_one_set,
  input wire logic vector_ack_zero,
  input wire logic vector_ack_one,
  input wire logic irq_en_zero,
  input wire logic irq_en_one,
  output logic irq_zero,
  output logic irq_one,
  output logic timer_one_overflow
);

  // ************************************************************
  // Helper functions
  // ************************************************************
  // Prescaler terminal count for each prescale setting
  function automatic logic [5:0] ps_limit(input logic [1:0] sca);
    case (sca)
      DTM_SCA_DIV12: ps_limit = DTM_LIM_DIV12;
      DTM_SCA_DIV4: ps_limit = DTM_LIM_DIV4;
      DTM_SCA_DIV48: ps_limit = DTM_LIM_DIV48;
      DTM_SCA_EXT8: ps_limit = DTM_LIM_EXT8;
      default: ps_limit = DTM_LIM_DIV12;
    endcase
  endfunction

  // Byte write over the bus to a given register address; the bit path is not included
  function automatic logic hit(input logic [7:0] a);
    hit = sfr_we && (sfr_addr == a);
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  dtm_run_flag_t timer_run_and_flag_control_reg, timer_run_and_flag_control_next;
  dtm_mode_t timer_mode_register_reg, timer_mode_register_next;
  dtm_clk_ctrl_t ckcon_reg, ckcon_next;
  logic [7:0] tl0_reg, tl0_next, th0_reg, th0_next;
  logic [7:0] tl1_reg, tl1_next, th1_reg, th1_next;
  logic [5:0] ps_reg, ps_next;
  logic ext_clk_s1_reg, ext_clk_s2_reg, ext_clk_s3_reg;
  logic pin0_d_reg, pin1_d_reg;
  logic [7:0] rdata_reg, rdata_next;
  logic irq0_reg, irq0_next, irq1_reg, irq1_next;
  logic ovf1_reg, ovf1_next;

  // ************************************************************
  // Tick sources
  // ************************************************************
  logic ext_fall, ps_step, ps_tick, pin0_fall, pin1_fall;
  logic clk0_tick, clk1_tick, cnt0_tick, cnt1_tick;
  logic zero_gate_select_ok, gate1_ok, run0, run_split_high, run1;
  logic split;

  // Edges and prescaler tick; first sync stage feeds only the second
  always_comb begin
    ext_fall = ext_clk_s3_reg && !ext_clk_s2_reg;
    pin0_fall = pin0_d_reg && !timer_zero_count_pin;
    pin1_fall = pin1_d_reg && !timer_one_count_pin;
    ps_step = (ckcon_reg.tick_prescale_field == DTM_SCA_EXT8) ? ext_fall : 1'b1;
    ps_tick = ps_step && (ps_reg >= ps_limit(ckcon_reg.tick_prescale_field));
    if (ps_step) begin
      ps_next = ps_tick ? DTM_PS_ZERO : ps_reg + DTM_PS_ONE;
    end else begin
      ps_next = ps_reg;
    end
    clk0_tick = ckcon_reg.zero_sys_clock ? 1'b1 : ps_tick;
    clk1_tick = ckcon_reg.one_sys_clock ? 1'b1 : ps_tick;
    split = (timer_mode_register_reg.zero_mode == DTM_MODE_SPLIT);
    cnt0_tick = timer_mode_register_reg.zero_counter_select ? pin0_fall : clk0_tick;
    // Timer one loses its pin while timer zero is split
    cnt1_tick = (timer_mode_register_reg.one_counter_select && !split) ? pin1_fall : clk1_tick;
    zero_gate_select_ok = !timer_mode_register_reg.zero_gate_select || (ext_input_zero == ext_zero_polarity);
    gate1_ok = !timer_mode_register_reg.one_gate_select || (ext_input_one == ext_one_polarity);
    run0 = timer_run_and_flag_control_reg.zero_run_bit && zero_gate_select_ok;
    run_split_high = split && timer_run_and_flag_control_reg.one_run_bit;
    if (timer_mode_register_reg.one_mode == DTM_MODE_SPLIT) begin
      run1 = 1'b0;
    end else if (split) begin
      run1 = 1'b1;
    end else begin
      run1 = timer_run_and_flag_control_reg.one_run_bit && gate1_ok;
    end
  end

  // ************************************************************
  // Counting
  // ************************************************************
  logic ovf0, ovf0_high, ovf1;
  logic [13:0] sum13_0, sum13_1;
  logic [16:0] sum16_0, sum16_1;
  logic [8:0] sumlo_0, sumlo_1, sumhi_0;

  // Count paths per mode; bus writes to a byte override the count
  always_comb begin
    tl0_next = tl0_reg;
    th0_next = th0_reg;
    tl1_next = tl1_reg;
    th1_next = th1_reg;
    ovf0 = 1'b0;
    ovf0_high = 1'b0;
    ovf1 = 1'b0;
    sum13_0 = {1'b0, th0_reg, tl0_reg[DTM_LOW13_MSB:0]} + 14'h0001;
    sum16_0 = {1'b0, th0_reg, tl0_reg} + 17'h00001;
    sumlo_0 = {1'b0, tl0_reg} + 9'h001;
    sumhi_0 = {1'b0, th0_reg} + 9'h001;
    sum13_1 = {1'b0, th1_reg, tl1_reg[DTM_LOW13_MSB:0]} + 14'h0001;
    sum16_1 = {1'b0, th1_reg, tl1_reg} + 17'h00001;
    sumlo_1 = {1'b0, tl1_reg} + 9'h001;
    // Timer zero
    if (run0 && cnt0_tick) begin
      case (timer_mode_register_reg.zero_mode)
        DTM_MODE_13: begin
          {th0_next, tl0_next[DTM_LOW13_MSB:0]} = sum13_0[12:0];
          ovf0 = sum13_0[13];
        end
        DTM_MODE_16: begin
          {th0_next, tl0_next} = sum16_0[15:0];
          ovf0 = sum16_0[16];
        end
        DTM_MODE_RELOAD: begin
          tl0_next = sumlo_0[8] ? th0_reg : sumlo_0[7:0];
          ovf0 = sumlo_0[8];
        end
        DTM_MODE_SPLIT: begin
          tl0_next = sumlo_0[7:0];
          ovf0 = sumlo_0[8];
        end
        default: ovf0 = 1'b0;
      endcase
    end
    // Split high byte is a timer only, never the pin
    if (run_split_high && clk0_tick) begin
      th0_next = sumhi_0[7:0];
      ovf0_high = sumhi_0[8];
    end
    // Timer one
    if (run1 && cnt1_tick) begin
      case (timer_mode_register_reg.one_mode)
        DTM_MODE_13: begin
          {th1_next, tl1_next[DTM_LOW13_MSB:0]} = sum13_1[12:0];
          ovf1 = sum13_1[13];
        end
        DTM_MODE_16: begin
          {th1_next, tl1_next} = sum16_1[15:0];
          ovf1 = sum16_1[16];
        end
        DTM_MODE_RELOAD: begin
          tl1_next = sumlo_1[8] ? th1_reg : sumlo_1[7:0];
          ovf1 = sumlo_1[8];
        end
        default: ovf1 = 1'b0;
      endcase
    end
    // Software write wins over a count in the same cycle
    if (hit(DTM_ADDR_ZERO_LOW)) tl0_next = sfr_wdata;
    if (hit(DTM_ADDR_ZERO_HIGH)) th0_next = sfr_wdata;
    if (hit(DTM_ADDR_ONE_LOW)) tl1_next = sfr_wdata;
    if (hit(DTM_ADDR_ONE_HIGH)) th1_next = sfr_wdata;
  end

  // ************************************************************
  // Registers reached over the special function bus
  // ************************************************************
  logic one_flag_set;

  // Control registers; hardware sets are applied last so they win
  always_comb begin
    timer_run_and_flag_control_next = timer_run_and_flag_control_reg;
    timer_mode_register_next = timer_mode_register_reg;
    ckcon_next = ckcon_reg;
    if (hit(DTM_ADDR_RUN_FLAG)) timer_run_and_flag_control_next = dtm_run_flag_t'(sfr_wdata);
    if (hit(DTM_ADDR_MODE)) timer_mode_register_next = dtm_mode_t'(sfr_wdata);
    if (hit(DTM_ADDR_CLK_CTRL)) ckcon_next = dtm_clk_ctrl_t'(sfr_wdata);
    ckcon_next.unused = 3'h0;
    ckcon_next.spare = 1'b0;
    // Single-bit write into the bit-addressable control register
    if (sfr_bit_we && (sfr_bit_addr[7:3] == DTM_BIT_BASE)) begin
      case (sfr_bit_addr[2:0])
        3'h7: timer_run_and_flag_control_next.one_overflow_flag = sfr_bit_val;
        3'h6: timer_run_and_flag_control_next.one_run_bit = sfr_bit_val;
        3'h5: timer_run_and_flag_control_next.zero_overflow_flag = sfr_bit_val;
        3'h4: timer_run_and_flag_control_next.zero_run_bit = sfr_bit_val;
        3'h3: timer_run_and_flag_control_next.ext_one_flag = sfr_bit_val;
        3'h2: timer_run_and_flag_control_next.ext_one_type = sfr_bit_val;
        3'h1: timer_run_and_flag_control_next.ext_zero_flag = sfr_bit_val;
        3'h0: timer_run_and_flag_control_next.ext_zero_type = sfr_bit_val;
        default: timer_run_and_flag_control_next = timer_run_and_flag_control_next;
      endcase
    end
    // Vectoring to the routine clears its flag
    if (vector_ack_zero) timer_run_and_flag_control_next.zero_overflow_flag = 1'b0;
    if (vector_ack_one) timer_run_and_flag_control_next.one_overflow_flag = 1'b0;
    // Timer one cannot flag while timer zero is split
    one_flag_set = split ? ovf0_high : ovf1;
    if (ovf0) timer_run_and_flag_control_next.zero_overflow_flag = 1'b1;
    if (one_flag_set) timer_run_and_flag_control_next.one_overflow_flag = 1'b1;
    if (ext_zero_set) timer_run_and_flag_control_next.ext_zero_flag = 1'b1;
    if (ext_one_set) timer_run_and_flag_control_next.ext_one_flag = 1'b1;
  end

  // Read data, interrupts and overflow strobe
  always_comb begin
    rdata_next = rdata_reg;
    if (sfr_re) begin
      case (sfr_addr)
        DTM_ADDR_RUN_FLAG: rdata_next = timer_run_and_flag_control_reg;
        DTM_ADDR_MODE: rdata_next = timer_mode_register_reg;
        DTM_ADDR_ZERO_LOW: rdata_next = tl0_reg;
        DTM_ADDR_ZERO_HIGH: rdata_next = th0_reg;
        DTM_ADDR_ONE_LOW: rdata_next = tl1_reg;
        DTM_ADDR_ONE_HIGH: rdata_next = th1_reg;
        DTM_ADDR_CLK_CTRL: rdata_next = ckcon_reg;
        default: rdata_next = DTM_RESET_BYTE;
      endcase
    end
    irq0_next = irq_en_zero && timer_run_and_flag_control_next.zero_overflow_flag;
    irq1_next = irq_en_one && timer_run_and_flag_control_next.one_overflow_flag;
    // Baud and converter trigger see timer one even when split
    ovf1_next = ovf1;
  end

  // ************************************************************
  // Flip-flops
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timer_run_and_flag_control_reg <= dtm_run_flag_t'(DTM_RESET_BYTE);
      timer_mode_register_reg <= dtm_mode_t'(DTM_RESET_BYTE);
      ckcon_reg <= dtm_clk_ctrl_t'(DTM_RESET_BYTE);
      tl0_reg <= DTM_RESET_BYTE;
      th0_reg <= DTM_RESET_BYTE;
      tl1_reg <= DTM_RESET_BYTE;
      th1_reg <= DTM_RESET_BYTE;
      ps_reg <= DTM_PS_ZERO;
      ext_clk_s1_reg <= 1'b0;
      ext_clk_s2_reg <= 1'b0;
      ext_clk_s3_reg <= 1'b0;
      pin0_d_reg <= 1'b0;
      pin1_d_reg <= 1'b0;
      rdata_reg <= DTM_RESET_BYTE;
      irq0_reg <= 1'b0;
      irq1_reg <= 1'b0;
      ovf1_reg <= 1'b0;
    end else begin
      timer_run_and_flag_control_reg <= timer_run_and_flag_control_next;
      timer_mode_register_reg <= timer_mode_register_next;
      ckcon_reg <= ckcon_next;
      tl0_reg <= tl0_next;
      th0_reg <= th0_next;
      tl1_reg <= tl1_next;
      th1_reg <= th1_next;
      ps_reg <= ps_next;
      ext_clk_s1_reg <= ext_clk;
      ext_clk_s2_reg <= ext_clk_s1_reg;
      ext_clk_s3_reg <= ext_clk_s2_reg;
      pin0_d_reg <= timer_zero_count_pin;
      pin1_d_reg <= timer_one_count_pin;
      rdata_reg <= rdata_next;
      irq0_reg <= irq0_next;
      irq1_reg <= irq1_next;
      ovf1_reg <= ovf1_next;
    end
  end

  // Outputs straight from flops
  assign sfr_rdata = rdata_reg;
  assign irq_zero = irq0_reg;
  assign irq_one = irq1_reg;
  assign timer_one_overflow = ovf1_reg;

endmodule // dtm_timers

// ### dtm_pkg.sv
package dtm_pkg;

  // ************************************************************
  // Special function register addresses
  // ************************************************************
  localparam logic [7:0] DTM_ADDR_RUN_FLAG = 8'h88;
  localparam logic [7:0] DTM_ADDR_MODE = 8'h89;
  localparam logic [7:0] DTM_ADDR_ZERO_LOW = 8'h8A;
  localparam logic [7:0] DTM_ADDR_ONE_LOW = 8'h8B;
  localparam logic [7:0] DTM_ADDR_ZERO_HIGH = 8'h8C;
  localparam logic [7:0] DTM_ADDR_ONE_HIGH = 8'h8D;
  localparam logic [7:0] DTM_ADDR_CLK_CTRL = 8'h8E;
  // Bit addresses of the run/flag register share its upper five bits
  localparam logic [4:0] DTM_BIT_BASE = 5'h11;

  // ************************************************************
  // Reset values and field constants
  // ************************************************************
  localparam logic [7:0] DTM_RESET_BYTE = 8'h00;
  localparam logic [1:0] DTM_MODE_13 = 2'h0;
  localparam logic [1:0] DTM_MODE_16 = 2'h1;
  localparam logic [1:0] DTM_MODE_RELOAD = 2'h2;
  localparam logic [1:0] DTM_MODE_SPLIT = 2'h3;
  localparam logic [1:0] DTM_SCA_DIV12 = 2'h0;
  localparam logic [1:0] DTM_SCA_DIV4 = 2'h1;
  localparam logic [1:0] DTM_SCA_DIV48 = 2'h2;
  localparam logic [1:0] DTM_SCA_EXT8 = 2'h3;
  localparam logic [5:0] DTM_LIM_DIV12 = 6'h0B;
  localparam logic [5:0] DTM_LIM_DIV4 = 6'h03;
  localparam logic [5:0] DTM_LIM_DIV48 = 6'h2F;
  localparam logic [5:0] DTM_LIM_EXT8 = 6'h07;
  localparam logic [5:0] DTM_PS_ZERO = 6'h00;
  localparam logic [5:0] DTM_PS_ONE = 6'h01;
  localparam int DTM_LOW13_MSB = 4;

  // ************************************************************
  // Register layouts
  // ************************************************************
  typedef struct packed {
    logic one_overflow_flag;
    logic one_run_bit;
    logic zero_overflow_flag;
    logic zero_run_bit;
    logic ext_one_flag;
    logic ext_one_type;
    logic ext_zero_flag;
    logic ext_zero_type;
  } dtm_run_flag_t;

  typedef struct packed {
    logic one_gate_select;
    logic one_counter_select;
    logic [1:0] one_mode;
    logic zero_gate_select;
    logic zero_counter_select;
    logic [1:0] zero_mode;
  } dtm_mode_t;

  typedef struct packed {
    logic [2:0] unused;
    logic one_sys_clock;
    logic zero_sys_clock;
    logic spare;
    logic [1:0] tick_prescale_field;
  } dtm_clk_ctrl_t;

endpackage : dtm_pkg

// ### dtm_asserts.sv
module dtm_asserts
  import dtm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_we,
  input wire logic sfr_re,
  input wire logic sfr_bit_we,
  input wire logic [7:0] sfr_rdata,
  input wire logic irq_en_zero,
  input wire logic irq_en_one,
  input wire logic irq_zero,
  input wire logic irq_one,
  input wire logic timer_one_overflow
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Byte write immediately followed by a clean read of the same place
  sequence s_wr_rd(a);
    sfr_we && sfr_addr == a ##1 sfr_re && !sfr_we && !sfr_bit_we && sfr_addr == a;
  endsequence

  // Holes in the map read as zero
  property p_unmapped;
    sfr_re && (sfr_addr < 8'h88 || sfr_addr > 8'h8E) |=> sfr_rdata == 8'h00;
  endproperty
  // Read data only moves on a read strobe
  property p_hold;
    !sfr_re |=> $stable(sfr_rdata);
  endproperty
  // Run and type bits are never touched by hardware, so they read back as written
  property p_run_rb;
    s_wr_rd(DTM_ADDR_RUN_FLAG) |=> (sfr_rdata & 8'h55) == ($past(sfr_wdata, 2) & 8'h55);
  endproperty
  property p_mode_rb;
    s_wr_rd(DTM_ADDR_MODE) |=> sfr_rdata == $past(sfr_wdata, 2);
  endproperty
  // Unused clock control bits must read zero
  property p_clk_rb;
    s_wr_rd(DTM_ADDR_CLK_CTRL) |=> sfr_rdata == ($past(sfr_wdata, 2) & 8'h1B);
  endproperty
  // No request while the enable is low
  property p_irq0_off;
    !irq_en_zero |=> !irq_zero;
  endproperty
  property p_irq1_off;
    !irq_en_one |=> !irq_one;
  endproperty
  property p_irq0_rise;
    $rose(irq_zero) |-> $past(irq_en_zero);
  endproperty

  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_hold: assert property (p_hold) else $error("read data moved without read");
  a_run_rb: assert property (p_run_rb) else $error("run bits readback wrong");
  a_mode_rb: assert property (p_mode_rb) else $error("mode readback wrong");
  a_clk_rb: assert property (p_clk_rb) else $error("clock control readback wrong");
  a_irq0_off: assert property (p_irq0_off) else $error("irq zero while disabled");
  a_irq1_off: assert property (p_irq1_off) else $error("irq one while disabled");
  a_irq0_rise: assert property (p_irq0_rise) else $error("irq zero rose without enable");

  c_irq0: cover property ($rose(irq_zero));
  c_irq1: cover property ($rose(irq_one));
  c_ovf1: cover property (timer_one_overflow);
endmodule // dtm_asserts

bind dtm_timers dtm_asserts u_chk (.clk, .rst, .sfr_addr, .sfr_wdata, .sfr_we, .sfr_re, .sfr_bit_we,
  .sfr_rdata, .irq_en_zero, .irq_en_one, .irq_zero, .irq_one, .timer_one_overflow);

// ### dtm_pins.sv
module dtm_pins (
  input wire logic clk,
  output logic timer_zero_count_pin,
  output logic timer_one_count_pin,
  output logic ext_input_zero,
  output logic ext_input_one
);
  timeunit 1ns;
  timeprecision 1ps;
  // Count pins rest high as a pulled-up line would; gates start inactive
  initial begin
    {timer_zero_count_pin, timer_one_count_pin} = 2'b11;
    {ext_input_zero, ext_input_one} = 2'b00;
  end
  // One falling edge per pulse, each level a full cycle so it is sampled
  task automatic pulse(input int w, input int n);
    repeat (n) begin
      @(negedge clk);
      if (w == 0) timer_zero_count_pin = 1'b0;
      else timer_one_count_pin = 1'b0;
      @(negedge clk);
      {timer_zero_count_pin, timer_one_count_pin} = 2'b11;
      @(negedge clk);
    end
  endtask
  // Gate level, judged by the block against its polarity input
  task automatic gate(input int w, input logic l);
    if (w == 0) ext_input_zero = l;
    else ext_input_one = l;
  endtask
endmodule // dtm_pins

// ### tb.sv
module tb
  import dtm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] SCA [3] = '{DTM_SCA_DIV4, DTM_SCA_DIV12, DTM_SCA_DIV48};
  localparam int EXP [3] = '{120, 40, 10};
  logic clk = 1'b0, rst = 1'b1, sfr_we = 1'b0, sfr_re = 1'b0, sfr_bit_we = 1'b0, sfr_bit_val = 1'b0;
  logic vector_ack_zero = 1'b0, vector_ack_one = 1'b0, irq_en_zero = 1'b0, irq_en_one = 1'b0;
  logic ext_zero_polarity = 1'b1, ext_one_polarity = 1'b1, ext_clk = 1'b0, ext_zero_set = 1'b0, ext_one_set = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_bit_addr = 8'h00, v, w;
  wire logic [7:0] sfr_rdata;
  wire logic timer_zero_count_pin, timer_one_count_pin, ext_input_zero, ext_input_one;
  wire logic irq_zero, irq_one, timer_one_overflow;
  int miscompares = 0, n_checks = 0, ovf_seen = 0, o;

  dtm_timers dut (.clk, .rst, .sfr_addr, .sfr_wdata, .sfr_we, .sfr_re, .sfr_bit_we, .sfr_bit_addr,
    .sfr_bit_val, .sfr_rdata, .timer_zero_count_pin, .timer_one_count_pin, .ext_input_zero,
    .ext_input_one, .ext_zero_polarity, .ext_one_polarity, .ext_clk, .ext_zero_set,
    .ext_one_set, .vector_ack_zero, .vector_ack_one, .irq_en_zero, .irq_en_one, .irq_zero,
    .irq_one, .timer_one_overflow);
  dtm_pins pins (.clk, .timer_zero_count_pin, .timer_one_count_pin, .ext_input_zero, .ext_input_one);

  always #2 clk = ~clk;
  // Pulses are single cycles, so count them here rather than poll
  always @(posedge clk) if (timer_one_overflow === 1'b1) ovf_seen++;

  // Every strobe is set anew at each falling edge, so none is assigned twice
  task automatic bus(input logic [2:0] s, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {sfr_we, sfr_re, sfr_bit_we} = s;
    sfr_addr = a;
    sfr_bit_addr = a;
    sfr_wdata = d;
    sfr_bit_val = d[0];
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(3'b100, a, d);
  endtask
  task automatic idle(input int n);
    repeat (n) bus(3'b000, 8'h00, 8'h00);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] r);
    bus(3'b010, a, 8'h00);
    idle(1);
    r = sfr_rdata;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a, v);
    chk(v, e);
  endtask
  task automatic pul(input int wh, input int n);
    idle(1);
    pins.pulse(wh, n);
    idle(2);
  endtask
  task automatic stop_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Whole run is a few thousand cycles; this limit is far past it
  initial begin
    #100000;
    miscompares++;
    stop_test();
  end

  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    // Reset values, then a hole in the map
    for (int a = 8'h88; a <= 8'h8E; a++) rc(8'(a), DTM_RESET_BYTE);
    rc(8'h80, 8'h00);
    wr(DTM_ADDR_MODE, 8'h01);
    rc(DTM_ADDR_MODE, 8'h01);
    wr(DTM_ADDR_CLK_CTRL, 8'hFF);
    rc(DTM_ADDR_CLK_CTRL, 8'h1B);
    // 480 cycles of 16-bit timing per divider; phase of the divider allows one count either way
    foreach (SCA[i]) begin
      wr(DTM_ADDR_ZERO_LOW, 8'h00);
      wr(DTM_ADDR_CLK_CTRL, {6'h00, SCA[i]});
      wr(DTM_ADDR_RUN_FLAG, 8'h10);
      idle(479);
      wr(DTM_ADDR_RUN_FLAG, 8'h00);
      rd(DTM_ADDR_ZERO_LOW, v);
      n_checks++;
      if ($isunknown(v) || v < EXP[i] - 1 || v > EXP[i] + 1) begin
        miscompares++;
        $display("[FAIL] %0t prescaled count %h", $time, v);
      end
    end
    // External clock: 16 falling edges through the synchroniser give two ticks
    wr(DTM_ADDR_ZERO_LOW, 8'h00);
    wr(DTM_ADDR_CLK_CTRL, {6'h00, DTM_SCA_EXT8});
    wr(DTM_ADDR_RUN_FLAG, 8'h10);
    repeat (32) begin
      idle(2);
      ext_clk = ~ext_clk;
    end
    idle(4);
    wr(DTM_ADDR_RUN_FLAG, 8'h00);
    rc(DTM_ADDR_ZERO_LOW, 8'h02);
    // Gated pin counting in 16-bit mode
    wr(DTM_ADDR_CLK_CTRL, 8'h18);
    wr(DTM_ADDR_MODE, 8'h0D);
    wr(DTM_ADDR_ZERO_LOW, 8'h00);
    wr(DTM_ADDR_ZERO_HIGH, 8'h00);
    wr(DTM_ADDR_RUN_FLAG, 8'h10);
    pul(0, 2);
    rc(DTM_ADDR_ZERO_LOW, 8'h00);
    pins.gate(0, 1'b1);
    pul(0, 2);
    rc(DTM_ADDR_ZERO_LOW, 8'h02);
    wr(DTM_ADDR_ZERO_LOW, 8'hFF);
    wr(DTM_ADDR_ZERO_HIGH, 8'h12);
    pul(0, 1);
    rc(DTM_ADDR_ZERO_LOW, 8'h00);
    rc(DTM_ADDR_ZERO_HIGH, 8'h13);
    // 13-bit mode: the low byte's top three bits ride along untouched
    wr(DTM_ADDR_MODE, 8'h0C);
    wr(DTM_ADDR_ZERO_LOW, 8'hFF);
    wr(DTM_ADDR_ZERO_HIGH, 8'hFF);
    pul(0, 1);
    rc(DTM_ADDR_ZERO_LOW, 8'hE0);
    rc(DTM_ADDR_ZERO_HIGH, 8'h00);
    rc(DTM_ADDR_RUN_FLAG, 8'h30);
    bus(3'b001, 8'h8D, 8'h00);
    rc(DTM_ADDR_RUN_FLAG, 8'h10);
    // Auto-reload on timer zero, then the vector clears the flag
    wr(DTM_ADDR_MODE, 8'h06);
    wr(DTM_ADDR_ZERO_HIGH, 8'hF0);
    wr(DTM_ADDR_ZERO_LOW, 8'hFE);
    irq_en_zero = 1'b1;
    pul(0, 3);
    rc(DTM_ADDR_ZERO_LOW, 8'hF1);
    rc(DTM_ADDR_ZERO_HIGH, 8'hF0);
    rc(DTM_ADDR_RUN_FLAG, 8'h30);
    chk({7'h00, irq_zero}, 8'h01);
    vector_ack_zero = 1'b1;
    idle(1);
    vector_ack_zero = 1'b0;
    idle(1);
    chk({7'h00, irq_zero}, 8'h00);
    rc(DTM_ADDR_RUN_FLAG, 8'h10);
    // Auto-reload on timer one, flag cleared by a bit write
    wr(DTM_ADDR_RUN_FLAG, 8'h40);
    wr(DTM_ADDR_MODE, 8'hE0);
    wr(DTM_ADDR_ONE_HIGH, 8'h80);
    wr(DTM_ADDR_ONE_LOW, 8'hFF);
    irq_en_one = 1'b1;
    // Gate closed while the input differs from its polarity, then opened
    pul(1, 1);
    rc(DTM_ADDR_ONE_LOW, 8'hFF);
    ext_one_polarity = 1'b0;
    o = ovf_seen;
    pul(1, 1);
    rc(DTM_ADDR_ONE_LOW, 8'h80);
    rc(DTM_ADDR_RUN_FLAG, 8'hC0);
    chk({7'h00, irq_one}, 8'h01);
    chk(8'(ovf_seen - o), 8'h01);
    bus(3'b001, 8'h8F, 8'h00);
    rc(DTM_ADDR_RUN_FLAG, 8'h40);
    // Flag sets arriving with a byte write that clears them must stick
    wr(DTM_ADDR_RUN_FLAG, 8'h40);
    {ext_zero_set, ext_one_set} = 2'b11;
    idle(1);
    {ext_zero_set, ext_one_set} = 2'b00;
    rc(DTM_ADDR_RUN_FLAG, 8'h4A);
    // Split mode: timer one free-runs and strobes its overflow but sets no flag
    wr(DTM_ADDR_RUN_FLAG, 8'h00);
    wr(DTM_ADDR_MODE, 8'h67);
    wr(DTM_ADDR_ZERO_LOW, 8'h00);
    wr(DTM_ADDR_ZERO_HIGH, 8'hFE);
    wr(DTM_ADDR_ONE_HIGH, 8'h00);
    bus(3'b001, 8'h8C, 8'h01);
    o = ovf_seen;
    pul(0, 2);
    rc(DTM_ADDR_ZERO_LOW, 8'h02);
    rc(DTM_ADDR_ZERO_HIGH, 8'hFE);
    idle(300);
    rc(DTM_ADDR_RUN_FLAG, 8'h10);
    chk({7'h00, irq_one}, 8'h00);
    chk({7'h00, 1'(ovf_seen > o)}, 8'h01);
    bus(3'b001, 8'h8E, 8'h01);
    idle(4);
    rc(DTM_ADDR_RUN_FLAG, 8'hD0);
    chk({7'h00, irq_one}, 8'h01);
    wr(DTM_ADDR_MODE, 8'h77);
    idle(2);
    rd(DTM_ADDR_ONE_LOW, w);
    idle(5);
    rc(DTM_ADDR_ONE_LOW, w);
    stop_test();
  end
endmodule // tb
